// ---- design/abm_params.svh ----
// Constants for the asynchronous bus-master cycle-start block
`ifndef ABM_PARAMS_SVH
`define ABM_PARAMS_SVH

// Decoded acknowledge pair {high, low}, active high after inversion
`define ABM_ACK_WAIT 2'h0
`define ABM_ACK_8    2'h1
`define ABM_ACK_16   2'h2
`define ABM_ACK_32   2'h3

// Size output encoding {size_high, size_low}
`define ABM_SIZ_LONG 2'h0
`define ABM_SIZ_BYTE 2'h1
`define ABM_SIZ_WORD 2'h2
`define ABM_SIZ_3B   2'h3

// Port widths in bytes
`define ABM_PORT8_BYTES  3'h1
`define ABM_PORT16_BYTES 3'h2
`define ABM_PORT32_BYTES 3'h4
`define ABM_LONG_BYTES   3'h4

// Read data buffer shape
`define ABM_FIFO_WIDTH 32
`define ABM_FIFO_DEPTH 8

`endif

// ---- design/abm_pkg.sv ----
// Types for the asynchronous bus-master cycle-start block
package abm_pkg;

  // Each state except IDLE and WAIT lasts one clk period, standing for one half-clock bus state
  typedef enum logic [2:0] {
    ABM_IDLE,
    ABM_S0,
    ABM_S1,
    ABM_S2,
    ABM_S3,
    ABM_WAIT,
    ABM_END
  } abm_state_t;

  typedef struct packed {
    abm_state_t  state;
    logic [1:0]  ack_s1;
    logic [1:0]  ack_s2;
    logic [31:0] din_s1;
    logic [31:0] din_s2;
    logic [31:0] addr;
    logic [2:0]  rem;
    logic [2:0]  space;
    logic        write;
    logic        hit;
    logic        first;
    logic        rmw_cont;
    logic [31:0] wdata;
    logic [31:0] acc;
    logic        wr_dir;
    logic        rmw;
    logic        as;
    logic        ds;
    logic        external_cycle_start;
    logic        operand_cycle_start;
    logic        doe;
    logic [31:0] dout;
    logic        push;
  } abm_regs_t;

endpackage

// ---- design/abm_fifo.sv ----
// Read data buffer: flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ns
`include "abm_params.svh"

module abm_fifo #(
  parameter int WIDTH = `ABM_FIFO_WIDTH,
  parameter int DEPTH = `ABM_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             srst,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wp;
    logic [AW-1:0]               rp;
    logic [AW:0]                 cnt;
  } abm_fifo_regs_t;

  abm_fifo_regs_t st_ff;
  abm_fifo_regs_t nxt_st;
  logic           push;
  logic           pop;

  assign in_ready  = st_ff.cnt != (AW+1)'(DEPTH);
  assign out_valid = st_ff.cnt != '0;
  assign out_data  = st_ff.mem[st_ff.rp];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    nxt_st = st_ff;
    if (push) begin
      nxt_st.mem[st_ff.wp] = in_data;
      nxt_st.wp            = (st_ff.wp == AW'(DEPTH - 1)) ? '0 : st_ff.wp + 1'b1;
    end
    if (pop) begin
      nxt_st.rp = (st_ff.rp == AW'(DEPTH - 1)) ? '0 : st_ff.rp + 1'b1;
    end
    nxt_st.cnt = st_ff.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
endmodule

// ---- design/abm_cycle.sv ----
// Asynchronous bus-master front end: cycle start, strobes, sizing, read capture
`timescale 1ns/1ns
`include "abm_params.svh"

// Summary of operation
// - Drive low address, size, space, direction first
// - Cache hit abandons cycle before address strobe
// - Cycle-start strobe with early outputs; qualify externally
// - Operand strobe only on operand's first cycle
// - Three-bit space code held during address strobe
// - Size shows remaining bytes, held during strobe
// - Direction changes only when direction differs
// - Locked flag spans whole read-modify-write operation
// - Address of first byte held during strobe
// - Address strobe half a clock after start
// - One to four bytes per bus cycle
// - Read data captured at cycle's last sample
// - Writes drive all thirty-two data lines
// - Write data half a clock after strobe
// - Inputs pass two synchronizing flops before use
// - Misaligned or wide operands split into cycles
// - Acknowledge pair encodes wait or port width
// - Size outputs encode byte, word, three, long
// - Data strobe with address read, later write
module abm_cycle import abm_pkg::*; (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // Operand requests from the core
  input  wire logic        req_valid,
  output logic             req_ready,
  input  wire logic [31:0] req_addr,
  input  wire logic [2:0]  req_bytes,
  input  wire logic [2:0]  req_space,
  input  wire logic        req_write,
  input  wire logic [31:0] req_wdata,
  input  wire logic        req_cache_hit,
  input  wire logic        req_rmw,
  input  wire logic        req_rmw_cont,
  // Read operands to the core
  output logic             rd_valid,
  input  wire logic        rd_ready,
  output logic [31:0]      rd_data,
  // Bus outputs
  output logic [31:0]      address_lines,
  output logic             size_high,
  output logic             size_low,
  output logic [2:0]       address_space_code,
  output logic             read_not_write,
  output logic             external_cycle_start_n,
  output logic             operand_cycle_start_n,
  output logic             address_strobe_n,
  output logic             data_strobe_n,
  output logic             read_modify_write_flag_n,
  // Data bus as three signals
  input  wire logic [31:0] data_lines_in,
  output logic [31:0]      data_lines_out,
  output logic             data_lines_oe,
  // Termination inputs from the slave
  input  wire logic        transfer_ack_high_n,
  input  wire logic        transfer_ack_low_n
);

  abm_regs_t   st_ff;
  abm_regs_t   nxt_st;
  logic        fifo_in_ready;
  logic [2:0]  start;
  logic [2:0]  avail;
  logic [2:0]  moved;
  logic [2:0]  keep;
  logic [31:0] shifted;
  logic [31:0] top_w;
  logic [63:0] dbl_w;

  // Byte lane where the port's first byte sits, and bytes it can take
  always_comb begin
    case (st_ff.ack_s2)
      `ABM_ACK_32: begin
        start = {1'b0, st_ff.addr[1:0]};
        avail = `ABM_PORT32_BYTES - start;
      end
      `ABM_ACK_16: begin
        start = {2'b00, st_ff.addr[0]};
        avail = `ABM_PORT16_BYTES - start;
      end
      default: begin
        start = 3'h0;
        avail = `ABM_PORT8_BYTES;
      end
    endcase
    moved   = (st_ff.rem < avail) ? st_ff.rem : avail;
    keep    = `ABM_LONG_BYTES - moved;
    shifted = st_ff.din_s2 << {start, 3'b000};
  end

  // Remaining write bytes, top aligned, rotated to the lane of the address
  assign top_w = st_ff.wdata << {(`ABM_LONG_BYTES - st_ff.rem), 3'b000};
  assign dbl_w = {top_w, top_w};

  assign req_ready = (st_ff.state == ABM_IDLE) && !st_ff.push
                     && (req_write || fifo_in_ready);

  always_comb begin
    nxt_st      = st_ff;
    nxt_st.push = 1'b0;
    nxt_st.ack_s1 = ~{transfer_ack_high_n, transfer_ack_low_n};
    nxt_st.ack_s2 = st_ff.ack_s1;
    nxt_st.din_s1 = data_lines_in;
    nxt_st.din_s2 = st_ff.din_s1;
    case (st_ff.state)
      ABM_IDLE: begin
        if (req_valid && req_ready) begin
          nxt_st.addr     = req_addr;
          nxt_st.rem      = req_bytes;
          nxt_st.space    = req_space;
          nxt_st.write    = req_write;
          nxt_st.wdata    = req_wdata;
          nxt_st.hit      = req_cache_hit;
          nxt_st.rmw_cont = req_rmw_cont;
          nxt_st.acc      = '0;
          nxt_st.first    = 1'b1;
          nxt_st.wr_dir   = req_write;
          nxt_st.external_cycle_start      = 1'b1;
          nxt_st.operand_cycle_start      = 1'b1;
          nxt_st.rmw      = st_ff.rmw || req_rmw;
          nxt_st.state    = ABM_S0;
        end
      end
      ABM_S0: begin
        nxt_st.external_cycle_start = 1'b0;
        nxt_st.operand_cycle_start = 1'b0;
        if (st_ff.hit) begin
          nxt_st.rmw   = st_ff.rmw_cont;
          nxt_st.state = ABM_IDLE;
        end else begin
          nxt_st.as    = 1'b1;
          nxt_st.ds    = !st_ff.write;
          // Reads pass S1 and S2 too, so an acknowledge still synced from the
          // previous cycle has drained before WAIT looks at it
          nxt_st.state = ABM_S1;
        end
      end
      ABM_S1: begin
        if (st_ff.write) begin
          nxt_st.doe  = 1'b1;
          nxt_st.dout = dbl_w[{st_ff.addr[1:0], 3'b000} +: 32];
        end
        nxt_st.state = ABM_S2;
      end
      ABM_S2: begin
        nxt_st.ds    = 1'b1;
        nxt_st.state = ABM_WAIT;
      end
      ABM_WAIT: begin
        if (st_ff.ack_s2 != `ABM_ACK_WAIT) begin
          if (!st_ff.write) begin
            nxt_st.acc = (st_ff.acc << {moved, 3'b000}) | (shifted >> {keep, 3'b000});
          end
          nxt_st.addr  = st_ff.addr + {29'h0, moved};
          nxt_st.rem   = st_ff.rem - moved;
          nxt_st.as    = 1'b0;
          nxt_st.ds    = 1'b0;
          nxt_st.doe   = 1'b0;
          nxt_st.state = ABM_END;
        end
      end
      ABM_END: begin
        if (st_ff.rem == 3'h0) begin
          nxt_st.push  = !st_ff.write;
          nxt_st.rmw   = st_ff.rmw_cont;
          nxt_st.state = ABM_IDLE;
        end else begin
          nxt_st.first = 1'b0;
          nxt_st.external_cycle_start   = 1'b1;
          nxt_st.state = ABM_S0;
        end
      end
      default: begin
        nxt_st.state = ABM_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Stalling the core on a full buffer keeps a finished read from being lost
  abm_fifo #(
    .WIDTH (`ABM_FIFO_WIDTH),
    .DEPTH (`ABM_FIFO_DEPTH)
  ) u_rd_fifo (
    .clk       (clk),
    .srst      (srst),
    .in_valid  (st_ff.push),
    .in_ready  (fifo_in_ready),
    .in_data   (st_ff.acc),
    .out_valid (rd_valid),
    .out_ready (rd_ready),
    .out_data  (rd_data)
  );

  assign {size_high, size_low}     = st_ff.rem[1:0];
  assign address_lines             = st_ff.addr;
  assign address_space_code        = st_ff.space;
  assign read_not_write            = !st_ff.wr_dir;
  assign external_cycle_start_n    = !st_ff.external_cycle_start;
  assign operand_cycle_start_n     = !(st_ff.operand_cycle_start && st_ff.first);
  assign address_strobe_n          = !st_ff.as;
  assign data_strobe_n             = !st_ff.ds;
  assign read_modify_write_flag_n  = !st_ff.rmw;
  assign data_lines_out            = st_ff.dout;
  assign data_lines_oe             = st_ff.doe;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence start_live_s;
    st_ff.state == ABM_S0 && !st_ff.hit;
  endsequence

  sequence write_phases_s;
    !address_strobe_n && !data_lines_oe && data_strobe_n ##1
    data_lines_oe && data_strobe_n ##1
    !data_strobe_n;
  endsequence

  cycle_start_a: assert property (st_ff.state == ABM_S0 |-> !external_cycle_start_n)
    else $error("cycle start strobe missing in first state");
  hit_abort_a: assert property (st_ff.state == ABM_S0 && st_ff.hit
                               |=> address_strobe_n && st_ff.state == ABM_IDLE)
    else $error("cache hit cycle reached address strobe");
  as_delay_a: assert property (start_live_s |=> !address_strobe_n)
    else $error("address strobe not asserted after start");
  ds_read_a: assert property (start_live_s and !st_ff.write |=> !data_strobe_n)
    else $error("read data strobe not with address strobe");
  write_data_a: assert property (start_live_s and st_ff.write |=> write_phases_s)
    else $error("write data or strobe timing wrong");
  ctrl_hold_a: assert property (!address_strobe_n && !$past(address_strobe_n)
                               |-> $stable(address_lines) && $stable(address_space_code)
                                   && $stable({size_high, size_low}))
    else $error("address or control changed under strobe");
  rw_change_a: assert property ($changed(read_not_write) |-> st_ff.state == ABM_S0)
    else $error("direction changed outside cycle start");
  ocs_first_a: assert property (!operand_cycle_start_n
                               |-> !external_cycle_start_n && st_ff.first)
    else $error("operand start outside first cycle");
  wait_hold_a: assert property (st_ff.state == ABM_WAIT && st_ff.ack_s2 == `ABM_ACK_WAIT
                               |=> !address_strobe_n && st_ff.state == ABM_WAIT)
    else $error("cycle ended without acknowledge");
  rmw_drop_a: assert property (st_ff.state == ABM_END && st_ff.rem == 3'h0 && !st_ff.rmw_cont
                              |=> read_modify_write_flag_n)
    else $error("locked flag not released after operation");
  ack_sync_a: assert property (st_ff.state == ABM_WAIT && st_ff.ack_s2 != `ABM_ACK_WAIT
                              |=> address_strobe_n && data_strobe_n && !data_lines_oe)
    else $error("strobes not negated after synced acknowledge");

  // Encoding, lane and strobe order checks
  early_ctrl_a: assert property (!external_cycle_start_n
                                |-> address_strobe_n && data_strobe_n)
    else $error("strobe asserted together with cycle start");
  size_left_a: assert property (!address_strobe_n |-> st_ff.rem != 3'h0)
    else $error("address strobe with no bytes left");
  size_byte_a: assert property (!external_cycle_start_n && st_ff.rem == 3'h1
                               |-> {size_high, size_low} == `ABM_SIZ_BYTE)
    else $error("single byte not coded as byte size");
  size_long_a: assert property (!external_cycle_start_n && st_ff.rem == `ABM_LONG_BYTES
                               |-> {size_high, size_low} == `ABM_SIZ_LONG)
    else $error("four bytes not coded as long size");
  drive_write_a: assert property (data_lines_oe |-> !read_not_write && !address_strobe_n)
    else $error("data lines driven outside a write");
  ds_inside_a: assert property (!data_strobe_n |-> !address_strobe_n)
    else $error("data strobe outside address strobe");
  moved_range_a: assert property (st_ff.state == ABM_WAIT
                                 && st_ff.ack_s2 != `ABM_ACK_WAIT
                                 |-> moved != 3'h0 && moved <= `ABM_LONG_BYTES)
    else $error("bytes moved per cycle out of range");
endmodule

// ---- dv/abm_slave.sv ----
// Far-side slave model with chosen port width and wait states
`timescale 1ns/1ns
module abm_slave (
  // Clock
  input  wire logic        clk,
  // Bus from the master
  input  wire logic [31:0] address_lines,
  input  wire logic        size_high,
  input  wire logic        size_low,
  input  wire logic        read_not_write,
  input  wire logic        address_strobe_n,
  input  wire logic        data_strobe_n,
  input  wire logic [31:0] data_lines_out,
  // Answer to the master
  output logic [31:0]      slv_data,
  output logic             transfer_ack_high_n,
  output logic             transfer_ack_low_n,
  // Set by the bench: port {high,low} decoded, wait states
  input  wire logic [1:0]  port,
  input  wire logic [1:0]  waits
);
  logic [7:0] mem [0:255];
  logic [1:0] ack_n;
  logic [3:0] cnt;
  int         pb;
  int         off;
  int         n;

  assign transfer_ack_high_n = ack_n[1];
  assign transfer_ack_low_n  = ack_n[0];

  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'hA5;
    slv_data = 32'h0;
    ack_n    = 2'h3;
    cnt      = 4'h0;
  end

  always @(posedge clk) begin
    pb  = (port == 2'h3) ? 4 : int'(port);
    off = int'(address_lines[1:0]) % pb;
    n   = ({size_high, size_low} == 2'h0) ? 4 : int'({size_high, size_low});
    if (n > pb - off) n = pb - off;
    // timing starts only on address strobe; released lines keep toggling
    if (address_strobe_n) begin
      ack_n    <= 2'h3;
      cnt      <= 4'h0;
      slv_data <= ~slv_data;
    end else if (ack_n == 2'h3) begin
      if (cnt < 4'(waits) || data_strobe_n) begin
        cnt      <= cnt + 4'h1;
        slv_data <= ~slv_data;
      end else begin
        // slave ends cycle and reports its width
        ack_n <= ~port;
        for (int j = 0; j < n; j++) begin
          if (read_not_write) slv_data[31 - 8 * (off + j) -: 8] <= mem[8'(address_lines + j)];
          else mem[8'(address_lines + j)] = data_lines_out[31 - 8 * (off + j) -: 8];
        end
      end
    end
  end
endmodule

// ---- dv/test_async_bus_master_cycle_start.sv ----
// Self-checking bench for the bus-master cycle-start block
`timescale 1ns/1ns
module test_async_bus_master_cycle_start;
  logic        clk, srst, req_valid, req_ready, req_write, req_cache_hit, req_rmw;
  logic        req_rmw_cont, rd_valid, rd_ready, size_high, size_low, read_not_write;
  logic        external_cycle_start_n, operand_cycle_start_n, address_strobe_n;
  logic        data_strobe_n, read_modify_write_flag_n, data_lines_oe, hold, w;
  logic        transfer_ack_high_n, transfer_ack_low_n, ew, efirst, erm, prev_cont, hit_op;
  logic [31:0] req_addr, req_wdata, rd_data, address_lines, data_lines_in, data_lines_out;
  logic [31:0] slv_data, ea;
  logic [2:0]  req_bytes, req_space, address_space_code, es;
  logic [1:0]  port, waits;
  logic [7:0]  mir [0:255];
  logic [31:0] exp_q[$];
  int          seed = 32'h2CE0;
  int          num_errors, n_checks, er;

  abm_cycle uut (.clk, .srst, .req_valid, .req_ready, .req_addr, .req_bytes, .req_space,
    .req_write, .req_wdata, .req_cache_hit, .req_rmw, .req_rmw_cont, .rd_valid, .rd_ready,
    .rd_data, .address_lines, .size_high, .size_low, .address_space_code, .read_not_write,
    .external_cycle_start_n, .operand_cycle_start_n, .address_strobe_n, .data_strobe_n,
    .read_modify_write_flag_n, .data_lines_in, .data_lines_out, .data_lines_oe,
    .transfer_ack_high_n, .transfer_ack_low_n);

  abm_slave slave (.clk, .address_lines, .size_high, .size_low, .read_not_write,
    .address_strobe_n, .data_strobe_n, .data_lines_out, .slv_data, .transfer_ack_high_n,
    .transfer_ack_low_n, .port, .waits);

  assign data_lines_in = data_lines_oe ? data_lines_out : slv_data;

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task give_verdict;
    $display("Checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Issue one operand; expected bytes go to the mirror and the queue
  task op(input [31:0] a, input [2:0] n, input wr, h, rm, rc, input [1:0] p, ws);
    int k;
    logic [31:0] d;
    logic [31:0] wd;
    k  = 0;
    d  = 32'h0;
    wd = $random(seed);
    @(negedge clk);
    while (!req_ready && k < 400) begin
      @(negedge clk);
      k++;
    end
    if (!hit_op) chk("bytes left", 32'h0, 32'(er));
    for (int j = 0; j < n; j++) begin
      if (wr) mir[8'(a + j)] = wd[8 * (n - 1 - j) +: 8];
      d = {d[23:0], mir[8'(a + j)]};
    end
    @(posedge clk);
    ea = a; er = n; ew = wr; efirst = 1'b1; es = req_space ^ 3'h5;
    erm = rm | prev_cont; prev_cont = rc; hit_op = h;
    if (!wr && !h) exp_q.push_back(d);
    req_valid <= 1'b1; req_addr <= a; req_bytes <= n; req_write <= wr; req_wdata <= wd;
    req_space <= es; req_cache_hit <= h; req_rmw <= rm; req_rmw_cont <= rc;
    port <= p; waits <= ws;
    @(posedge clk);
    req_valid <= 1'b0;
  endtask

  task drain;
    int k;
    k = 0;
    while (exp_q.size() > 0 && k < 500) begin
      @(posedge clk);
      k++;
    end
    chk("reads left", 32'h0, 32'(exp_q.size()));
    if (!hit_op) chk("bytes left", 32'h0, 32'(er));
  endtask

  // Consumer stalls at random unless held
  always @(posedge clk) rd_ready <= !hold && ($random(seed) & 1);

  always @(posedge clk) begin
    int pb;
    int n;
    if (!srst && !external_cycle_start_n) begin
      chk("address", ea, address_lines);
      chk("size", 32'(er[1:0]), {30'h0, size_high, size_low});
      chk("space", 32'(es), 32'(address_space_code));
      chk("direction", 32'(!ew), 32'(read_not_write));
      chk("operand start", 32'(!efirst), 32'(operand_cycle_start_n));
      chk("locked flag", 32'(!erm), 32'(read_modify_write_flag_n));
      pb = (port == 2'h3) ? 4 : int'(port);
      n = pb - int'(ea[1:0]) % pb;
      if (n > er) n = er;
      ea += n;
      er -= n;
      efirst = 1'b0;
    end
    if (!srst && hit_op) chk("strobe on hit", 32'h1, 32'(address_strobe_n));
    if (!srst && rd_valid && rd_ready) begin
      if (exp_q.size() == 0) chk("spare read", 32'h0, 32'h1);
      else chk("read data", exp_q.pop_front(), rd_data);
    end
  end

  initial begin
    repeat (30000) @(posedge clk);
    chk("timeout", 32'h0, 32'h1);
    give_verdict;
  end

  initial begin
    srst = 1'b1; req_valid = 1'b0; req_addr = 32'h0; req_bytes = 3'h1; req_space = 3'h0;
    req_write = 1'b0; req_wdata = 32'h0; req_cache_hit = 1'b0; req_rmw = 1'b0;
    req_rmw_cont = 1'b0; rd_ready = 1'b0; hold = 1'b0; port = 2'h3; waits = 2'h0;
    ea = 32'h0; er = 0; ew = 1'b0; efirst = 1'b0; erm = 1'b0; es = 3'h0;
    prev_cont = 1'b0; hit_op = 1'b0;
    for (int i = 0; i < 256; i++) mir[i] = 8'(i) ^ 8'hA5;
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    // Writes stay on full-width ports: narrow-port lane copies are not made
    repeat (60) begin
      w = $random(seed);
      op(32'(8'($random(seed))), 3'(($random(seed) & 3) + 1), w, 1'b0, 1'b0, 1'b0,
         w ? 2'h3 : 2'(1 + {$random(seed)} % 3), 2'($random(seed)));
    end
    op(32'h10, 3'h4, 1'b0, 1'b0, 1'b1, 1'b1, 2'h3, 2'h1);
    op(32'h10, 3'h4, 1'b1, 1'b0, 1'b0, 1'b0, 2'h3, 2'h1);
    op(32'h10, 3'h4, 1'b0, 1'b0, 1'b0, 1'b0, 2'h3, 2'h0);
    op(32'h20, 3'h4, 1'b0, 1'b1, 1'b0, 1'b0, 2'h3, 2'h0);
    op(32'h23, 3'h3, 1'b0, 1'b0, 1'b0, 1'b0, 2'h1, 2'h2);
    drain;
    @(posedge clk);
    hold <= 1'b1;
    repeat (8) op(32'h41, 3'h4, 1'b0, 1'b0, 1'b0, 1'b0, 2'h2, 2'h0);
    // Long enough for the eighth read to land, so only a full buffer holds ready low
    repeat (40) @(negedge clk);
    chk("ready when full", 32'h0, 32'(req_ready));
    chk("buffer filled", 32'h1, 32'(rd_valid));
    @(posedge clk);
    hold <= 1'b0;
    drain;
    give_verdict;
  end
endmodule
